// *** ids_dispatch_top.sv ***
// instruction and dispatch registers, skip test and address steering
// How it works
// - dispatch register is 19 clocked-load bits
// - instruction load triggers dispatch load next clock
// - dispatch register updates one clock after instruction
// - next-instruction dispatch flag captured with control store
// - opcode top bits all ones means io
// - io address: 0-2, 7-9 ored 111, 10-12
// - io select is bits 3-9, internal if 3-6 zero
// - internal codes 000 to 024, 030 unused
// - nonzero bits 3-6 mean external device
// - other opcodes address same-numbered dispatch word
// - jump opcodes 254 and 255 use own locations
// - unconditional jump: j4 zero, j7-10 from ir
// - jump bits 00, 05, 06 not implemented
// - test pass is b0 xor resultant
// - skip-if-equal code 1 has sense bit zero
// - resultant: adder zero, b01 clear, magic #07
// - pc+1 select adds one unless inhibited
// - magic #01 with fetch and pass skips
// - skip outside interrupt cycle makes pc+2
// - address load needs select and fail-or-not-jump
// - jump fetch blocks skip, failed test loads pc+1
// - skips pick pc+1/pc+2, jumps target/pc+1
// - instruction register takes adder or cache data
//
// Design decisions made here: the register offsets and the APB slave port.
`default_nettype none
module ids_dispatch_top
	import ids_pkg::*;
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic [7:0]         paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic [0:IR_W-1]    adder_out,
	input  wire logic [0:IR_W-1]    cache_data,
	input  wire logic               mb_xfer,
	input  wire logic               load_instruction_cond,
	input  wire logic               next_instr_cond_dispatch,
	input  wire logic               control_store_load,
	input  wire logic [0:DREG_W-1]  dispatch_ram_data,
	input  wire logic               adder_zero,
	input  wire logic [0:8]         magic_number,
	input  wire logic               mem_fetch,
	input  wire logic               conditional_jump_function,
	input  wire logic               interrupt_service_cycle,
	input  wire logic               sequential_increment_inhibit,
	input  wire logic               address_select_bit_a,
	input  wire logic               address_select_bit_b,
	input  wire logic [VA_W-1:0]    pc,
	input  wire logic [VA_W-1:0]    jump_target,
	output logic [0:IR_W-1]         instr_reg,
	output logic [0:3]              instr_accum_field_reg,
	output logic [0:DADR_W-1]       dispatch_addr,
	output logic [0:DREG_W-1]       dispatch_reg,
	output logic                    dispatch_reg_load,
	output logic                    next_instr_cond_dispatch_latched,
	output logic                    io_opcode_detect,
	output ids_dev_type             device_class,
	output logic                    unconditional_jump_family,
	output logic                    flag_test_jump,
	output logic                    test_pass,
	output logic                    skip_taken,
	output logic                    address_increment,
	output logic [VA_W-1:0]         virtual_address_register
);
	logic                ir_load;
	logic                diag_strobe;
	logic [0:DREG_W-1]   next_dispatch;
	logic                pc1_func;
	logic                vma_load;
	logic [VA_W-1:0]     adder_a;
	logic [VA_W-1:0]     next_vma;
	logic [1:0]          incr;
	logic                wr_en;
	logic                rd_setup;
	logic                addr_ok;
	logic [31:0]         status_word;

	// console strobe reuses the normal load path for diagnostics
	assign ir_load = load_instruction_cond | diag_strobe;

	ids_addr_map u_addr_map (
		.instr                     (instr_reg),
		.dispatch_addr             (dispatch_addr),
		.io_opcode_detect          (io_opcode_detect),
		.unconditional_jump_family (unconditional_jump_family),
		.flag_test_jump            (flag_test_jump),
		.device_class              (device_class)
	);

	ids_test_eval u_test_eval (
		.b_field                 (dispatch_reg[DREG_B_POS +: 3]),
		.adder_zero              (adder_zero),
		.magic_number            (magic_number),
		.mem_fetch               (mem_fetch),
		.interrupt_service_cycle (interrupt_service_cycle),
		.test_pass               (test_pass),
		.skip_taken              (skip_taken),
		.address_increment       (address_increment)
	);

	// instruction register and accumulator field, adder unless mb transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_reg <= RST_IR;
			instr_accum_field_reg <= 4'h0;
		end else if (ir_load) begin
			instr_reg <= mb_xfer ? cache_data : adder_out;
			instr_accum_field_reg <= mb_xfer ? cache_data[9:12] : adder_out[9:12];
		end
	end

	// dispatch load trails the instruction load by exactly one clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dispatch_reg_load <= 1'b0;
		end else begin
			dispatch_reg_load <= ir_load;
		end
	end

	// ram word reshaped: missing jump bits stay zero, jump family remaps
	always_comb begin
		next_dispatch = dispatch_ram_data;
		next_dispatch[DREG_J_POS + 0] = 1'b0;
		next_dispatch[DREG_J_POS + 5] = 1'b0;
		next_dispatch[DREG_J_POS + 6] = 1'b0;
		if (unconditional_jump_family) begin
			next_dispatch[DREG_J_POS + 4] = 1'b0;
			next_dispatch[DREG_J_POS + 7 +: 4] = instr_reg[9:12];
		end
	end

	// ram is addressed by the register loaded one clock earlier
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dispatch_reg <= RST_DREG;
		end else if (dispatch_reg_load) begin
			dispatch_reg <= next_dispatch;
		end
	end

	// next-instruction dispatch flag, same edge as control store load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			next_instr_cond_dispatch_latched <= 1'b0;
		end else if (control_store_load) begin
			next_instr_cond_dispatch_latched <= next_instr_cond_dispatch;
		end
	end

	// address adder: pc plus one unless inhibited, or jump target; plus one more on a skip
	always_comb begin
		pc1_func = ~address_select_bit_a & address_select_bit_b;
		adder_a = pc1_func ? pc : jump_target;
		incr = {1'b0, pc1_func & ~sequential_increment_inhibit}
			+ {1'b0, address_increment};
		next_vma = adder_a + {{(VA_W-2){1'b0}}, incr};
	end

	// a passed jump test keeps the target already held
	assign vma_load = (address_select_bit_a | address_select_bit_b)
		& (~test_pass | ~conditional_jump_function);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			virtual_address_register <= RST_VA;
		end else if (vma_load) begin
			virtual_address_register <= next_vma;
		end
	end

	// apb slave, zero wait states; read data caught in the setup cycle
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign addr_ok = (paddr == REG_CTRL) | (paddr == REG_STATUS)
		| (paddr == REG_VADDR) | (paddr == REG_DISP);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	always_comb begin
		status_word = 32'h00000000;
		status_word[IR_W-1:0] = instr_reg;
		status_word[STAT_DEV_POS +: 3] = device_class;
		status_word[STAT_IO_BIT] = io_opcode_detect;
		status_word[STAT_TEST_BIT] = test_pass;
		status_word[STAT_SKIP_BIT] = skip_taken;
		status_word[STAT_NEXT_INSTR_COND_DISPATCH_BIT] = next_instr_cond_dispatch_latched;
		status_word[STAT_DLOAD_BIT] = dispatch_reg_load;
	end

	// strobe is a self-clearing one-clock pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diag_strobe <= 1'b0;
		end else begin
			diag_strobe <= wr_en & (paddr == REG_CTRL) & pwdata[CTRL_STROBE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			case (paddr)
				REG_CTRL:   prdata <= 32'h00000000;
				REG_STATUS: prdata <= status_word;
				REG_VADDR:  prdata <= {{(32-VA_W){1'b0}}, virtual_address_register};
				REG_DISP:   prdata <= {{(32-DREG_W){1'b0}}, dispatch_reg};
				default:    prdata <= 32'h00000000;
			endcase
		end
	end

	// checks on the load sequence, mapping and address steering
	chk_dreg_follows_ir: assert property (@(posedge pclk) disable iff (!presetn)
		ir_load |=> dispatch_reg_load)
		else $error("dispatch load did not follow instruction load");

	chk_dreg_one_late: assert property (@(posedge pclk) disable iff (!presetn)
		ir_load ##1 !ir_load |=> !dispatch_reg_load ##0 $stable(instr_reg))
		else $error("dispatch load not exactly one clock after instruction load");

	chk_ir_source: assert property (@(posedge pclk) disable iff (!presetn)
		ir_load && !mb_xfer |=> instr_reg == $past(adder_out))
		else $error("instruction register did not take adder output");

	chk_next_instr_cond_dispatch_capture: assert property (@(posedge pclk) disable iff (!presetn)
		control_store_load |=> next_instr_cond_dispatch_latched == $past(next_instr_cond_dispatch))
		else $error("next-instruction dispatch flag not captured");

	chk_io_address: assert property (@(posedge pclk) disable iff (!presetn)
		io_opcode_detect |-> dispatch_addr[3:5] == IO_FILL
			&& dispatch_addr[6:8] == instr_reg[10:12])
		else $error("io dispatch address malformed");

	chk_plain_address: assert property (@(posedge pclk) disable iff (!presetn)
		!io_opcode_detect |-> dispatch_addr == instr_reg[0:8])
		else $error("non-io dispatch address differs from opcode");

	chk_external_dev: assert property (@(posedge pclk) disable iff (!presetn)
		io_opcode_detect && instr_reg[3:6] != 4'h0 |-> device_class == DEV_EXTERNAL)
		else $error("external device select misclassified");

	chk_missing_jbits: assert property (@(posedge pclk) disable iff (!presetn)
		dispatch_reg_load |=> !dispatch_reg[DREG_J_POS] && !dispatch_reg[DREG_J_POS + 5]
			&& !dispatch_reg[DREG_J_POS + 6])
		else $error("unimplemented jump bit set");

	chk_jump_family_load: assert property (@(posedge pclk) disable iff (!presetn)
		dispatch_reg_load && unconditional_jump_family |=> !dispatch_reg[DREG_J_POS + 4]
			&& dispatch_reg[DREG_J_POS + 7 +: 4] == $past(instr_reg[9:12]))
		else $error("jump family dispatch bits wrong");

	chk_skip_pc2: assert property (@(posedge pclk) disable iff (!presetn)
		address_increment && pc1_func && !sequential_increment_inhibit
			&& vma_load |=> virtual_address_register == $past(pc) + 18'h00002)
		else $error("skip did not yield pc+2");

	chk_jump_keeps_target: assert property (@(posedge pclk) disable iff (!presetn)
		conditional_jump_function && test_pass |=> $stable(virtual_address_register))
		else $error("passed jump test reloaded the address");

	chk_jump_no_skip: assert property (@(posedge pclk) disable iff (!presetn)
		magic_number == MAGIC_JUMP_FETCH |-> !skip_taken)
		else $error("jump fetch produced a skip");

	cov_skip: cover property (@(posedge pclk) disable iff (!presetn)
		magic_number == MAGIC_COMP_FETCH && address_increment);
	cov_jump_hold: cover property (@(posedge pclk) disable iff (!presetn)
		conditional_jump_function && test_pass);
	cov_io_timer: cover property (@(posedge pclk) disable iff (!presetn)
		io_opcode_detect && device_class == DEV_TIMER);
	cov_jump_load: cover property (@(posedge pclk) disable iff (!presetn)
		ir_load ##1 dispatch_reg_load && unconditional_jump_family);
endmodule // ids_dispatch_top
`default_nettype wire

// *** ids_pkg.sv ***
// constants and types shared by the dispatch and skip-test logic
`default_nettype none
package ids_pkg;
	localparam int IR_W   = 13;
	localparam int DREG_W = 19;
	localparam int DADR_W = 9;
	localparam int VA_W   = 18;
	// apb register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_VADDR  = 8'h08;
	localparam logic [7:0] REG_DISP   = 8'h0C;
	localparam int CTRL_STROBE_BIT = 0;
	localparam int STAT_DEV_POS    = 13;
	localparam int STAT_IO_BIT     = 16;
	localparam int STAT_TEST_BIT   = 17;
	localparam int STAT_SKIP_BIT   = 18;
	localparam int STAT_NEXT_INSTR_COND_DISPATCH_BIT = 19;
	localparam int STAT_DLOAD_BIT  = 20;
	// reset values
	localparam logic [0:IR_W-1]   RST_IR   = 13'h0000;
	localparam logic [0:DREG_W-1] RST_DREG = 19'h00000;
	localparam logic [VA_W-1:0]   RST_VA   = 18'h00000;
	// dispatch register field positions, msb-first numbering
	localparam int DREG_B_POS = 3;
	localparam int DREG_J_POS = 8;
	// opcode and address mapping
	localparam logic [2:0] IO_PREFIX = 3'h7;
	localparam logic [2:0] IO_FILL   = 3'h7;
	localparam logic [DADR_W-1:0] OPC_UNCOND_JUMP = 9'h0AC;
	localparam logic [DADR_W-1:0] OPC_FLAG_JUMP   = 9'h0AD;
	localparam logic [2:0] SKIP_IF_EQUAL_CODE = 3'h1;
	localparam logic [0:8] MAGIC_COMP_FETCH   = 9'h081;
	localparam logic [0:8] MAGIC_JUMP_FETCH   = 9'h042;
	// internal device select codes, octal value shown as hex
	localparam logic [8:0] DEV_CODE_PROC  = 9'h000;
	localparam logic [8:0] DEV_CODE_INTR  = 9'h004;
	localparam logic [8:0] DEV_CODE_PAGE  = 9'h008;
	localparam logic [8:0] DEV_CODE_CACHE = 9'h00C;
	localparam logic [8:0] DEV_CODE_TIMER = 9'h010;
	localparam logic [8:0] DEV_CODE_METER = 9'h014;
	localparam logic [8:0] DEV_CODE_FREE  = 9'h018;
	typedef enum logic [2:0] {
		DEV_PROCESSOR_STATUS, DEV_INTERRUPT_SYSTEM, DEV_PAGING, DEV_CACHE_CONTROL,
		DEV_TIMER, DEV_METER, DEV_UNUSED, DEV_EXTERNAL
	} ids_dev_type;
endpackage
`default_nettype wire

// *** ids_addr_map.sv ***
// opcode to dispatch-ram address mapping and device classing
`default_nettype none
module ids_addr_map
	import ids_pkg::*;
(
	input  wire logic [0:IR_W-1]   instr,
	output logic [0:DADR_W-1]      dispatch_addr,
	output logic                   io_opcode_detect,
	output logic                   unconditional_jump_family,
	output logic                   flag_test_jump,
	output ids_dev_type            device_class
);
	logic [8:0] sel_code;

	// io opcodes use the compressed address form
	always_comb begin
		io_opcode_detect = (instr[0:2] == IO_PREFIX);
		sel_code = {instr[3:9], 2'b00};
		if (io_opcode_detect) begin
			dispatch_addr = {instr[0:2], instr[7:9] | IO_FILL, instr[10:12]};
		end else begin
			dispatch_addr = instr[0:8];
		end
	end

	// jump families decode straight from the opcode
	assign unconditional_jump_family = (instr[0:8] == OPC_UNCOND_JUMP);
	assign flag_test_jump            = (instr[0:8] == OPC_FLAG_JUMP);

	// nonzero bits 3-6 mean a device off the processor
	always_comb begin
		if (instr[3:6] != 4'h0) begin
			device_class = DEV_EXTERNAL;
		end else begin
			case (sel_code)
				DEV_CODE_PROC:  device_class = DEV_PROCESSOR_STATUS;
				DEV_CODE_INTR:  device_class = DEV_INTERRUPT_SYSTEM;
				DEV_CODE_PAGE:  device_class = DEV_PAGING;
				DEV_CODE_CACHE: device_class = DEV_CACHE_CONTROL;
				DEV_CODE_TIMER: device_class = DEV_TIMER;
				DEV_CODE_METER: device_class = DEV_METER;
				default:        device_class = DEV_UNUSED;
			endcase
		end
	end
endmodule // ids_addr_map
`default_nettype wire

// *** ids_test_eval.sv ***
// test-satisfied and skip-satisfied evaluation
`default_nettype none
module ids_test_eval
	import ids_pkg::*;
(
	input  wire logic [0:2] b_field,
	input  wire logic       adder_zero,
	input  wire logic [0:8] magic_number,
	input  wire logic       mem_fetch,
	input  wire logic       interrupt_service_cycle,
	output logic            test_pass,
	output logic            skip_taken,
	output logic            address_increment
);
	logic resultant;

	// only the equal term: adder zero with b01 clear and magic #07 set
	assign resultant = adder_zero & ~b_field[1] & magic_number[7];
	// b00 picks the sense; skip-if-equal code 1 keeps it clear
	assign test_pass = b_field[0] ^ resultant;
	// jump fetch magic has #01 clear, so it never skips
	assign skip_taken = magic_number[1] & mem_fetch & test_pass;
	// an interrupt cycle must not lose the instruction by skipping
	assign address_increment = skip_taken & ~interrupt_service_cycle;
endmodule // ids_test_eval
`default_nettype wire

// *** ids_dram_model.sv ***
// dispatch ram stand-in answering the dispatch address with a word
`default_nettype none
module ids_dram_model
	import ids_pkg::*;
(
	input  wire logic [0:DADR_W-1] dispatch_addr,
	output logic [0:DREG_W-1]      dispatch_ram_data
);
	timeunit 1ns;
	timeprecision 100ps;
	// address plus its complement, so every location and every J bit is distinct
	// and a stuck or swapped field never matches by chance
	assign dispatch_ram_data = {dispatch_addr, ~dispatch_addr, 1'b1};
endmodule // ids_dram_model
`default_nettype wire

// *** test_instr_dispatch_and_skip_test.sv ***
// self-checking bench for the dispatch and skip-test block
`default_nettype none
module test_instr_dispatch_and_skip_test
	import ids_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic                pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]          paddr = 8'h00;
	logic [31:0]         pwdata = 32'h0, prdata;
	logic                mb_xfer = 1'b0, load_instruction_cond = 1'b0, control_store_load = 1'b0;
	logic                next_instr_cond_dispatch = 1'b0, adder_zero = 1'b0, mem_fetch = 1'b0;
	logic                conditional_jump_function = 1'b0, interrupt_service_cycle = 1'b0;
	logic                sequential_increment_inhibit = 1'b0;
	logic                address_select_bit_a = 1'b0, address_select_bit_b = 1'b0;
	logic [0:IR_W-1]     adder_out = 13'h0000, cache_data = 13'h0000, instr_reg;
	logic [0:8]          magic_number = 9'h000;
	logic [VA_W-1:0]     pc = 18'h3FFFE, jump_target = 18'h01234, virtual_address_register;
	logic                pready, pslverr, dispatch_reg_load, next_instr_cond_dispatch_latched, io_opcode_detect;
	logic                unconditional_jump_family, flag_test_jump;
	logic                test_pass, skip_taken, address_increment;
	logic [0:3]          instr_accum_field_reg;
	logic [0:DADR_W-1]   dispatch_addr;
	logic [0:DREG_W-1]   dispatch_reg, dispatch_ram_data;
	ids_dev_type         device_class;
	int                  mismatches = 0, comparisons = 0;
	logic [VA_W-1:0]     exp_va = 18'h00000;
	logic                exp_nic = 1'b0;

	ids_dispatch_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .adder_out(adder_out), .cache_data(cache_data), .mb_xfer(mb_xfer),
		.load_instruction_cond(load_instruction_cond),
		.next_instr_cond_dispatch(next_instr_cond_dispatch),
		.control_store_load(control_store_load), .dispatch_ram_data(dispatch_ram_data),
		.adder_zero(adder_zero), .magic_number(magic_number), .mem_fetch(mem_fetch),
		.conditional_jump_function(conditional_jump_function),
		.interrupt_service_cycle(interrupt_service_cycle),
		.sequential_increment_inhibit(sequential_increment_inhibit),
		.address_select_bit_a(address_select_bit_a), .address_select_bit_b(address_select_bit_b),
		.pc(pc), .jump_target(jump_target), .instr_reg(instr_reg),
		.instr_accum_field_reg(instr_accum_field_reg), .dispatch_addr(dispatch_addr),
		.dispatch_reg(dispatch_reg), .dispatch_reg_load(dispatch_reg_load),
		.next_instr_cond_dispatch_latched(next_instr_cond_dispatch_latched), .io_opcode_detect(io_opcode_detect),
		.device_class(device_class), .unconditional_jump_family(unconditional_jump_family),
		.flag_test_jump(flag_test_jump), .test_pass(test_pass), .skip_taken(skip_taken),
		.address_increment(address_increment),
		.virtual_address_register(virtual_address_register));
	ids_dram_model i_dram (.dispatch_addr(dispatch_addr), .dispatch_ram_data(dispatch_ram_data));

	// 20 MHz clock
	always #25 pclk = ~pclk;

	// compare helpers, wider values zero-extended to one word
	task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chkv({31'h0, got}, {31'h0, exp});
	endtask

	// apb master: hold the request until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// expected dispatch address, dispatch word and device class
	function automatic logic [0:DADR_W-1] exp_addr(input logic [0:IR_W-1] v);
		return (v[0:2] == 3'h7) ? {v[0:2], 3'h7, v[10:12]} : v[0:8];
	endfunction
	function automatic logic [0:DREG_W-1] exp_dreg(input logic [0:IR_W-1] v);
		logic [0:DADR_W-1] a;
		logic [0:DREG_W-1] w;
		a = exp_addr(v);
		w = {a, ~a, 1'b1};
		w[8] = 1'b0; // missing J0
		w[13] = 1'b0;
		w[14] = 1'b0;
		if (a == OPC_UNCOND_JUMP) begin
			w[12] = 1'b0;
			w[15:18] = v[9:12];
		end
		return w;
	endfunction
	function automatic logic [2:0] exp_dev(input logic [0:IR_W-1] v);
		if (v[3:6] != 4'h0) return 3'h7;
		return (v[7:9] == 3'h7) ? 3'h6 : v[7:9];
	endfunction

	// one instruction load and the dispatch load that trails it
	task automatic load_ir(input logic [0:IR_W-1] v, input logic use_cache);
		@(posedge pclk);
		load_instruction_cond <= 1'b1;
		// park the address selects so a new b field cannot reload the address unseen
		address_select_bit_a <= 1'b0;
		address_select_bit_b <= 1'b0;
		mb_xfer    <= use_cache;
		adder_out  <= use_cache ? ~v : v;
		cache_data <= use_cache ? v : ~v;
		@(posedge pclk);
		load_instruction_cond <= 1'b0;
		adder_out <= ~v;
		#1;
		chkv(32'(instr_reg), 32'(v));
		chkv(32'(instr_accum_field_reg), 32'(v[9:12]));
		chk1(dispatch_reg_load, 1'b1);
		chkv(32'(dispatch_addr), 32'(exp_addr(v)));
		chk1(io_opcode_detect, v[0:2] == 3'h7);
		chk1(unconditional_jump_family, v[0:8] == OPC_UNCOND_JUMP);
		chk1(flag_test_jump, v[0:8] == OPC_FLAG_JUMP);
		if (v[0:2] == 3'h7) chkv(32'(device_class), 32'(exp_dev(v)));
		@(posedge pclk);
		#1;
		chk1(dispatch_reg_load, 1'b0);
		chkv(32'(dispatch_reg), 32'(exp_dreg(v)));
	endtask

	task automatic complete_run();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// a hang shows up as a missing pready or a stuck sequence
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end

	// test sequence
	initial begin
		logic [31:0] rd;
		logic er, z, tp, sk, inc;
		logic [0:IR_W-1] v;
		logic [0:IR_W-1] ops [0:3];
		logic [0:8] m;
		logic [0:8] mtab [0:2];
		logic [1:0] s;
		logic [2:0] b;
		ops = '{13'h0ACA, 13'h0AD5, 13'h1BF3, 13'h000F};
		mtab = '{9'h082, 9'h081, 9'h042};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chkv(32'(dispatch_reg), 32'h0);
		chkv(32'(virtual_address_register), 32'h0);
		$display("test reset done");
		for (int k = 0; k < 12; k++) begin
			v = (k < 4) ? ops[k] : {3'h7, (k == 11) ? 7'h29 : {4'h0, 3'(k - 4)}, 3'(k)};
			load_ir(v, k == 5);
		end
		// loads on consecutive edges
		@(posedge pclk);
		load_instruction_cond <= 1'b1;
		adder_out <= ops[2];
		@(posedge pclk);
		adder_out <= ops[0];
		@(posedge pclk);
		load_instruction_cond <= 1'b0;
		#1;
		chk1(dispatch_reg_load, 1'b1);
		chkv(32'(dispatch_reg), 32'(exp_dreg(ops[2])));
		@(posedge pclk);
		#1;
		chkv(32'(dispatch_reg), 32'(exp_dreg(ops[0])));
		$display("test opcode mapping done");
		for (int bi = 0; bi < 8; bi++) begin
			b = 3'(bi);
			load_ir({3'h1, b, 3'h2, 4'h0}, 1'b0);
			for (int i = 0; i < 6; i++) begin
				z = i[0];
				m = mtab[i / 2];
				s = 2'(i % 4);
				@(posedge pclk);
				adder_zero <= z;
				magic_number <= m;
				address_select_bit_a <= s[1];
				address_select_bit_b <= s[0];
				conditional_jump_function <= (i / 2 == 2);
				sequential_increment_inhibit <= b[1];
				interrupt_service_cycle <= b[2];
				mem_fetch <= (b != 3'h7);
				#1;
				// b00 is the msb of the b field, b01 the middle bit
				tp = b[2] ^ (z & ~b[1] & m[7]);
				sk = m[1] & (b != 3'h7) & tp;
				inc = sk & ~b[2];
				chk1(test_pass, tp);
				chk1(skip_taken, sk);
				chk1(address_increment, inc);
				if (s != 2'h0 && (!tp || i / 2 != 2))
					exp_va = ((s == 2'h1) ? pc : jump_target) + 18'((s == 2'h1) & ~b[1]) + 18'(inc);
				@(posedge pclk);
				#1;
				chkv(32'(virtual_address_register), 32'(exp_va));
			end
		end
		$display("test skip and address done");
		// capture only on control store load edges
		for (int k = 0; k < 3; k++) begin
			@(posedge pclk);
			control_store_load <= (k != 1);
			next_instr_cond_dispatch <= (k == 0);
			@(posedge pclk);
			#1;
			exp_nic = (k != 2);
			chk1(next_instr_cond_dispatch_latched, exp_nic);
		end
		$display("test dispatch flag done");
		@(posedge pclk);
		control_store_load <= 1'b0;
		address_select_bit_a <= 1'b0;
		address_select_bit_b <= 1'b0;
		v = {3'h7, 7'h02, 3'h5};
		adder_out <= v;
		apb(1'b1, REG_CTRL, 32'h1, rd, er);
		chk1(er, 1'b0);
		repeat (2) @(posedge pclk);
		apb(1'b0, REG_STATUS, 32'h0, rd, er);
		chkv(rd, {11'h0, 1'b0, exp_nic, 1'b0, 1'b1, 1'b1, 3'h2, v});
		apb(1'b1, 8'h14, 32'hFFFFFFFF, rd, er);
		chk1(er, 1'b1);
		apb(1'b0, REG_DISP, 32'h0, rd, er);
		chkv(rd, 32'(exp_dreg(v)));
		apb(1'b0, REG_VADDR, 32'h0, rd, er);
		chkv(rd, 32'(exp_va));
		apb(1'b0, REG_CTRL, 32'h0, rd, er);
		chkv(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0, rd, er);
		chkv({rd[30:0], er}, 32'h1);
		$display("test register access done");
		complete_run();
	end
endmodule // test_instr_dispatch_and_skip_test
`default_nettype wire
